/* File: core/i2c_link_pkg.sv */
// constants and types shared by the two-wire slave interface
package i2c_link_pkg;

   // fixed seven-bit slave address of the clock device
   localparam logic [6:0] SLAVE_ADDR = 7'h51;

   // register pointer width and its value after reset
   localparam int PTR_WIDTH = 5;
   localparam logic [PTR_WIDTH-1:0] PTR_RESET = 5'h00;

   // bits in one byte and the counter that walks them
   localparam int BYTE_BITS = 8;
   localparam int CNT_WIDTH = 4;
   localparam logic [CNT_WIDTH-1:0] CNT_BYTE_DONE = 4'h8;
   localparam logic [CNT_WIDTH-1:0] CNT_LAST_TX = 4'h7;

   // position of the direction bit in the address byte
   localparam int DIR_BIT = 0;

   // reset values of the byte registers and of a released pin
   localparam logic [BYTE_BITS-1:0] BYTE_RESET = 8'h00;
   localparam logic SDA_RELEASED = 1'h1;

   // protocol states of the link-side machine
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_PTR,
      ST_WDATA,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK
   } link_state_type;

endpackage

/* File: core/rtc_i2c_slave.sv */
// two-wire serial slave interface of the clock device
`timescale 1ns/10ps

module rtc_i2c_slave (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_link,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic reg_wr,
   output logic reg_rd,
   output logic [i2c_link_pkg::PTR_WIDTH-1:0] reg_addr,
   output logic [i2c_link_pkg::BYTE_BITS-1:0] reg_wdata,
   input wire logic [i2c_link_pkg::BYTE_BITS-1:0] reg_rdata
);
   import i2c_link_pkg::*;

   // pointer plus one, wrapping inside the register space
   function automatic logic [PTR_WIDTH-1:0] next_ptr(
      input logic [PTR_WIDTH-1:0] p
   );
      next_ptr = p + {{(PTR_WIDTH-1){1'h0}}, 1'h1};
   endfunction

   // true when the upper seven bits of a byte carry our address
   function automatic logic addr_match(input logic [BYTE_BITS-1:0] b);
      addr_match = (b[BYTE_BITS-1:1] == SLAVE_ADDR);
   endfunction

   // link domain state
   logic rst_link_s1;
   logic rst_link;
   logic scl_s1;
   logic scl_s2;
   logic scl_d;
   logic sda_s1;
   logic sda_s2;
   logic sda_d;
   link_state_type state;
   logic [CNT_WIDTH-1:0] bit_cnt;
   logic [BYTE_BITS-1:0] shift;
   logic [PTR_WIDTH-1:0] ptr;
   logic read_dir;
   logic master_ack;
   logic [PTR_WIDTH-1:0] wr_addr;
   logic [BYTE_BITS-1:0] wr_data;
   logic wr_tgl;
   logic [PTR_WIDTH-1:0] rd_addr;
   logic rd_tgl;
   logic [BYTE_BITS-1:0] rd_buf;
   logic rsp_s1;
   logic rsp_s2;
   logic rsp_s3;

   // system domain state
   logic wr_s1;
   logic wr_s2;
   logic wr_s3;
   logic rd_s1;
   logic rd_s2;
   logic rd_s3;
   logic rsp_tgl;
   logic [BYTE_BITS-1:0] rdata_hold;

   // decoded bus events, all from the second sync stage onward
   logic start_cond;
   logic stop_cond;
   logic scl_rise;
   logic scl_fall;
   logic rsp_evt;
   logic wr_evt;
   logic rd_evt;

   // reset reaches the link domain through two flops
   // so link logic leaves reset a few clk_link edges after rst falls
   always_ff @(posedge clk_link) begin
      rst_link_s1 <= rst;
      rst_link <= rst_link_s1;
   end

   // pins are foreign to clk_link: two flops, then one for edge history
   // no glitch filter: a spike wider than one clk_link period is seen
   always_ff @(posedge clk_link) begin
      if (rst_link) begin
         scl_s1 <= 1'h1;
         scl_s2 <= 1'h1;
         scl_d <= 1'h1;
         sda_s1 <= 1'h1;
         sda_s2 <= 1'h1;
         sda_d <= 1'h1;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   // sda edges with scl held high are control, not data
   assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign scl_rise = scl_s2 & ~scl_d;
   assign scl_fall = ~scl_s2 & scl_d;
   assign rsp_evt = rsp_s2 ^ rsp_s3;

   // the pin is open drain: the driven level is always low
   always_ff @(posedge clk_link) begin
      sda_out <= 1'h0;
   end

   // read answers come back from the system side as a toggle
   // rd_buf only loads once rdata_hold has settled behind the toggle
   always_ff @(posedge clk_link) begin
      if (rst_link) begin
         rsp_s1 <= 1'h0;
         rsp_s2 <= 1'h0;
         rsp_s3 <= 1'h0;
         rd_buf <= BYTE_RESET;
      end else begin
         rsp_s1 <= rsp_tgl;
         rsp_s2 <= rsp_s1;
         rsp_s3 <= rsp_s2;
         // rdata_hold stays still from its toggle until the next request
         if (rsp_evt) begin
            rd_buf <= rdata_hold;
         end
      end
   end

   // protocol machine; sda only changes right after scl falls
   // start and stop outrank every state, so a frame cut short always
   // lands in a known place and the next start is never missed
   always_ff @(posedge clk_link) begin
      if (rst_link) begin
         state <= ST_IDLE;
         bit_cnt <= '0;
         shift <= BYTE_RESET;
         ptr <= PTR_RESET;
         read_dir <= 1'h0;
         master_ack <= 1'h0;
         sda_oe_n <= SDA_RELEASED;
         wr_addr <= PTR_RESET;
         wr_data <= BYTE_RESET;
         wr_tgl <= 1'h0;
         rd_addr <= PTR_RESET;
         rd_tgl <= 1'h0;
      end else if (start_cond) begin
         // a repeated start also closes any write in progress
         state <= ST_ADDR;
         bit_cnt <= '0;
         sda_oe_n <= SDA_RELEASED;
      end else if (stop_cond) begin
         state <= ST_IDLE;
         sda_oe_n <= SDA_RELEASED;
      end else begin
         case (state)
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (scl_rise) begin
                  // msb arrives first
                  shift <= {shift[BYTE_BITS-2:0], sda_s2};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == CNT_BYTE_DONE) begin
                  bit_cnt <= '0;
                  if (state == ST_ADDR) begin
                     if (addr_match(shift)) begin
                        sda_oe_n <= 1'h0;
                        read_dir <= shift[DIR_BIT];
                        state <= ST_ADDR_ACK;
                        if (shift[DIR_BIT]) begin
                           // fetch early so the byte is ready after ack
                           rd_addr <= ptr;
                           rd_tgl <= ~rd_tgl;
                        end
                     end else begin
                        // another device's frame: stay off the line
                        state <= ST_IDLE;
                     end
                  end else if (state == ST_PTR) begin
                     // top three bits of the byte are dropped
                     ptr <= shift[PTR_WIDTH-1:0];
                     sda_oe_n <= 1'h0;
                     state <= ST_RX_ACK;
                  end else begin
                     wr_addr <= ptr;
                     wr_data <= shift;
                     wr_tgl <= ~wr_tgl;
                     ptr <= next_ptr(ptr);
                     sda_oe_n <= 1'h0;
                     state <= ST_RX_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               // ack is held low through the whole ninth clock
               if (scl_fall) begin
                  bit_cnt <= '0;
                  if (read_dir) begin
                     shift <= rd_buf;
                     ptr <= next_ptr(ptr);
                     sda_oe_n <= rd_buf[BYTE_BITS-1];
                     state <= ST_TX;
                  end else begin
                     sda_oe_n <= SDA_RELEASED;
                     state <= ST_PTR;
                  end
               end
            end
            ST_RX_ACK: begin
               // let go at the fall that ends the ninth clock
               if (scl_fall) begin
                  sda_oe_n <= SDA_RELEASED;
                  state <= ST_WDATA;
               end
            end
            ST_TX: begin
               // bit_cnt counts bits already sent; the msb left at ack end
               if (scl_fall) begin
                  if (bit_cnt == CNT_LAST_TX) begin
                     // let go for the master's ack, prefetch next byte
                     sda_oe_n <= SDA_RELEASED;
                     state <= ST_TX_ACK;
                     rd_addr <= ptr;
                     rd_tgl <= ~rd_tgl;
                  end else begin
                     shift <= {shift[BYTE_BITS-2:0], 1'h0};
                     sda_oe_n <= shift[BYTE_BITS-2];
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            ST_TX_ACK: begin
               // the master's answer is taken at scl rise, once settled
               if (scl_rise) begin
                  master_ack <= ~sda_s2;
               end else if (scl_fall) begin
                  bit_cnt <= '0;
                  if (master_ack) begin
                     shift <= rd_buf;
                     ptr <= next_ptr(ptr);
                     sda_oe_n <= rd_buf[BYTE_BITS-1];
                     state <= ST_TX;
                  end else begin
                     // a released line is also what recovery clocks see
                     sda_oe_n <= SDA_RELEASED;
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               // idle ignores stray clocks until the next start
               sda_oe_n <= SDA_RELEASED;
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // link toggles cross into clk_sys through two flops plus history
   // toggles, not pulses: no event is lost whatever the clock ratio,
   // as long as events stay a byte time apart
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_s1 <= 1'h0;
         wr_s2 <= 1'h0;
         wr_s3 <= 1'h0;
         rd_s1 <= 1'h0;
         rd_s2 <= 1'h0;
         rd_s3 <= 1'h0;
      end else begin
         wr_s1 <= wr_tgl;
         wr_s2 <= wr_s1;
         wr_s3 <= wr_s2;
         rd_s1 <= rd_tgl;
         rd_s2 <= rd_s1;
         rd_s3 <= rd_s2;
      end
   end

   // one-cycle events from the second and third flops
   assign wr_evt = wr_s2 ^ wr_s3;
   assign rd_evt = rd_s2 ^ rd_s3;

   // wr_addr, wr_data and rd_addr are stable for a whole byte after
   // their toggle, so they are read here without their own sync
   // one transfer has one direction, so a write and a read never meet
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_wr <= 1'h0;
         reg_rd <= 1'h0;
         reg_addr <= PTR_RESET;
         reg_wdata <= BYTE_RESET;
      end else begin
         reg_wr <= wr_evt;
         reg_rd <= rd_evt & ~wr_evt;
         if (wr_evt) begin
            reg_addr <= wr_addr;
            reg_wdata <= wr_data;
         end else if (rd_evt) begin
            reg_addr <= rd_addr;
         end
      end
   end

   // the register file answers during the reg_rd cycle
   // trade-off: a register written after its prefetch goes out stale,
   // but the link never has to stretch scl to wait for the answer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_hold <= BYTE_RESET;
         rsp_tgl <= 1'h0;
      end else if (reg_rd) begin
         rdata_hold <= reg_rdata;
         rsp_tgl <= ~rsp_tgl;
      end
   end

endmodule

/* File: sim/rtc_i2c_slave_checker.sv */
// concurrent checks on the pins and strobes of the two-wire slave
`timescale 1ns/10ps
module rtc_i2c_slave_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_link,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [i2c_link_pkg::PTR_WIDTH-1:0] reg_addr,
   input wire logic [i2c_link_pkg::BYTE_BITS-1:0] reg_wdata,
   input wire logic [i2c_link_pkg::BYTE_BITS-1:0] reg_rdata
);
   import i2c_link_pkg::*;
   // out of reset: strobes quiet, pointer at zero, sda released
   property p_rst_quiet;
      @(posedge clk_sys) disable iff (rst) $fell(rst) |-> !reg_wr &&
         !reg_rd && reg_addr == PTR_RESET && reg_wdata == BYTE_RESET &&
         sda_oe_n == SDA_RELEASED;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("reset");
   // a write strobe is one cycle and at least eight clk_sys cycles apart from the next
   property p_wr_gap;
      @(posedge clk_sys) disable iff (rst) reg_wr |=> (!reg_wr && !reg_rd)[*8];
   endproperty
   a_wr_gap: assert property (p_wr_gap)
      else $error("write gap");
   property p_rd_gap;
      @(posedge clk_sys) disable iff (rst) reg_rd |=> (!reg_rd && !reg_wr)[*8];
   endproperty
   a_rd_gap: assert property (p_rd_gap)
      else $error("read gap");
   // open drain: the level is always low, only the enable moves
   property p_drive_low;
      @(posedge clk_link) disable iff (rst) sda_out == 1'h0;
   endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("sda high");
   // the device moves sda only while scl is low
   property p_move_low;
      @(posedge clk_link) disable iff (rst) $changed(sda_oe_n) |-> !scl_in;
   endproperty
   a_move_low: assert property (p_move_low)
      else $error("sda moved");
   // a low held into scl high stays until scl falls
   property p_hold_high;
      @(posedge clk_link) disable iff (rst)
         !sda_oe_n && scl_in |=> !sda_oe_n || !scl_in;
   endproperty
   a_hold_high: assert property (p_hold_high)
      else $error("ack lost");
   // for eight clk_link cycles after a stop or a start the device stays off the line
   property p_stop_idle;
      @(posedge clk_link) disable iff (rst)
         scl_in && $rose(sda_in) |=> sda_oe_n[*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("stop");
   property p_start_idle;
      @(posedge clk_link) disable iff (rst)
         scl_in && $fell(sda_in) |=> sda_oe_n[*8];
   endproperty
   a_start_idle: assert property (p_start_idle)
      else $error("start");
   c_write: cover property (@(posedge clk_sys) reg_wr);
   c_read: cover property (@(posedge clk_sys) reg_rd);
   c_ack: cover property (@(posedge clk_link) $fell(sda_oe_n));
endmodule

bind rtc_i2c_slave rtc_i2c_slave_checker rtc_i2c_slave_checker_i (
   .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
);

/* File: sim/i2c_master_model.sv */
// behavioural bus master driving scl and its own pull on sda
`timescale 1ns/10ps
module i2c_master_model (
   input wire logic clk_link,
   input wire logic sda_in,
   output logic scl,
   output logic sda_m
);
   localparam int QTR = 40; // quarter bit; keeps scl low near 1 us
   logic r;
   initial begin
      scl = 1'h1;
      sda_m = 1'h1;
   end
   // wait a quarter bit, then move both lines just after a clock edge
   task automatic q(input logic c, input logic d);
      repeat (QTR) @(posedge clk_link);
      scl <= c;
      sda_m <= d;
   endtask
   // also serves as repeated start; called with the bus free or mid transfer
   task automatic start();
      q(1'h0, sda_m);
      q(1'h0, 1'h1);
      q(1'h1, 1'h1);
      q(1'h1, 1'h0);
   endtask
   task automatic stop();
      q(1'h0, sda_m);
      q(1'h0, 1'h0);
      q(1'h1, 1'h0);
      q(1'h1, 1'h1);
   endtask
   // data set while scl low, sampled halfway through the high phase
   task automatic pulse(input logic d, output logic v);
      q(1'h0, sda_m);
      q(1'h0, d);
      q(1'h1, d);
      repeat (QTR) @(posedge clk_link);
      v = sda_in;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic a,
                       output logic [7:0] rx, output logic ak);
      for (int i = 7; i >= 0; i--) begin
         pulse(tx[i], rx[i]);
      end
      pulse(a, ak);
   endtask
   // blind clocks with sda released, to free a stuck bus
   task automatic clocks(input int n);
      repeat (n) pulse(1'h1, r);
   endtask
endmodule

/* File: sim/test_rtc_i2c_slave.sv */
// self-checking bench: bus master model against the two-wire slave
`timescale 1ns/10ps
module test_rtc_i2c_slave;
   import i2c_link_pkg::*;
   logic clk_sys = 1'h0;
   logic clk_link = 1'h0;
   logic rst = 1'h1;
   logic scl, sda_m, sda_out, sda_oe_n, reg_wr, reg_rd, ack;
   logic [PTR_WIDTH-1:0] reg_addr;
   logic [BYTE_BITS-1:0] reg_wdata, rx;
   logic [BYTE_BITS-1:0] regs [32];
   int err_total = 0;
   int check_count = 0;
   wire logic sda_w = sda_m & sda_oe_n; // pull-up unless someone pulls low
   always #20 clk_sys = ~clk_sys;
   // link clock offset so its edges never meet the system clock's
   initial begin
      #2.5;
      forever #6 clk_link = ~clk_link;
   end
   // register file behind the strobes; reads are combinational
   always @(posedge clk_sys) begin
      if (reg_wr) begin
         regs[reg_addr] <= reg_wdata;
      end
   end
   rtc_i2c_slave rtc_i2c_slave_i (
      .clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(regs[reg_addr])
   );
   i2c_master_model mst (
      .clk_link(clk_link), .sda_in(sda_w), .scl(scl), .sda_m(sda_m)
   );
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // pointer byte with top bits set, then two data bytes
   task automatic t_write();
      mst.start();
      mst.xfer({SLAVE_ADDR, 1'h0}, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h00);
      mst.xfer(8'hE3, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h00);
      mst.xfer(8'h5A, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h00);
      mst.xfer(8'hA5, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h00);
      mst.stop();
      chk(regs[3], 8'h5A);
      chk(regs[4], 8'hA5);
   endtask
   task automatic t_wrong();
      mst.start();
      mst.xfer({7'h52, 1'h0}, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h01);
      mst.xfer(8'h05, 1'h1, rx, ack);
      mst.xfer(8'h77, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h01);
      mst.stop();
      chk(regs[5], 8'h39);
   endtask
   // a partial byte cut off by a stop must not be written
   task automatic t_abort();
      mst.start();
      mst.xfer({SLAVE_ADDR, 1'h0}, 1'h1, rx, ack);
      mst.xfer(8'h06, 1'h1, rx, ack);
      mst.xfer(8'h11, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h00);
      repeat (3) mst.pulse(1'h0, ack);
      mst.stop();
      chk(regs[6], 8'h11);
      chk(regs[7], 8'h3B);
   endtask
   // pointer at the top, repeated start, read wraps to zero
   task automatic t_read();
      mst.start();
      mst.xfer({SLAVE_ADDR, 1'h0}, 1'h1, rx, ack);
      mst.xfer(8'h1F, 1'h1, rx, ack);
      mst.start();
      mst.xfer({SLAVE_ADDR, 1'h1}, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h00);
      mst.xfer(8'hFF, 1'h0, rx, ack);
      chk(rx, 8'h23);
      mst.xfer(8'hFF, 1'h1, rx, ack);
      chk(rx, 8'h3C);
      chk({7'h0, ack}, 8'h01);
      // hold scl low past the device's answer to the not-acknowledge
      mst.q(1'h0, 1'h1);
      mst.q(1'h0, 1'h1);
      chk({7'h0, sda_w}, 8'h01);
      mst.stop();
   endtask
   // master loses its place mid read, recovers with nine clocks
   task automatic t_recover();
      mst.start();
      mst.xfer({SLAVE_ADDR, 1'h1}, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h00);
      repeat (3) mst.pulse(1'h1, ack);
      mst.clocks(9);
      chk({7'h0, sda_w}, 8'h01);
      mst.stop();
      mst.start();
      mst.xfer({SLAVE_ADDR, 1'h0}, 1'h1, rx, ack);
      chk({7'h0, ack}, 8'h00);
      mst.stop();
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge clk_sys);
      err_total++;
      print_verdict();
   end
   initial begin
      for (int i = 0; i < 32; i++) begin
         regs[i] = 8'h3C ^ 8'(i);
      end
      repeat (16) @(posedge clk_sys);
      rst <= 1'h0;
      repeat (10) @(posedge clk_sys);
      t_write();
      t_wrong();
      t_abort();
      t_read();
      t_recover();
      print_verdict();
   end
endmodule
